//--- mbs_cfg.svh
`ifndef MBS_CFG_SVH
`define MBS_CFG_SVH

`define MBS_CLK_HZ 200000000
`define MBS_BAUD 9600
`define MBS_BIT_CYCLES ((`MBS_CLK_HZ + `MBS_BAUD / 2) / `MBS_BAUD)
`define MBS_CHAR_BITS 4'hB
`define MBS_SILENCE_TENTHS 35
`define MBS_SILENCE_CYCLES \
    ((`MBS_BIT_CYCLES * 11 * `MBS_SILENCE_TENTHS + 9) / 10)
`define MBS_TABLE_ITEMS 10000
`define MBS_INDEX_BITS 14
`define MBS_BLOCK_LIMIT 7500
`define MBS_FC_RD_COILS 8'h01
`define MBS_FC_RD_DISC 8'h02
`define MBS_FC_RD_HOLD 8'h03
`define MBS_FC_RD_INPUT 8'h04
`define MBS_FC_WR_COIL 8'h05
`define MBS_FC_WR_REG 8'h06
`define MBS_FC_DIAG 8'h08
`define MBS_FC_WR_COILS 8'h0F
`define MBS_FC_WR_REGS 8'h10
`define MBS_EXC_FLAG 8'h80
`define MBS_EXC_NONE 8'h00
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_ADDR 8'h02
`define MBS_EXC_VALUE 8'h03
`define MBS_MAX_RD_BITS 16'h07D0
`define MBS_MAX_RD_REGS 16'h007D
`define MBS_MAX_WR_COILS 16'h0200
`define MBS_MAX_WR_REGS 16'h007B
`define MBS_COIL_ON 16'hFF00
`define MBS_COIL_OFF 16'h0000
`define MBS_BUF_BYTES 9'h100
`define MBS_MIN_FRAME 9'h004
`define MBS_FIXED_REQ 9'h008
`define MBS_MULTI_BASE 9'h009
`define MBS_CRC_BYTES 9'h002
`define MBS_EXC_LEN 9'h003
`define MBS_ECHO_LEN 9'h006
`define MBS_RD_HDR 16'h0003
`define MBS_WR_HDR 16'h0007
`define MBS_BROADCAST 8'h00
`define MBS_CRC_INIT 16'hFFFF
`define MBS_CRC_POLY 16'hA001

`endif

//--- mbs_chk.sv
`timescale 1ns/1ps
module mbs_chk #(
    parameter int ITEMS = 10000,
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_pin,
    input wire logic tx_pin,
    input wire logic app_we,
    input wire mbs_pkg::mbs_table_t app_table,
    input wire logic [13:0] app_index,
    input wire logic [15:0] app_wdata,
    input wire logic [15:0] app_rdata
);
    import mbs_pkg::*;
    int low_run;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk)
        low_run <= (!nrst || tx_pin) ? 0 : low_run + 1;
    property p_rb(mbs_table_t t, logic [15:0] m);
        app_we && app_table == t && app_index < ITEMS ##1
        (!app_we && app_table == t && $stable(app_index)) [*2]
        |-> (app_rdata & m) == ($past(app_wdata, 2) & m);
    endproperty
    a_reset_idle: assert property ($rose(nrst) |-> tx_pin)
        else $error("not idle");
    a_coil_back: assert property (p_rb(tbl_coil, 16'h0001))
        else $error("coil back");
    a_disc_back: assert property (p_rb(tbl_disc, 16'h0001))
        else $error("disc back");
    a_ireg_back: assert property (p_rb(tbl_ireg, 16'hFFFF))
        else $error("ireg back");
    a_hreg_back: assert property (p_rb(tbl_hreg, 16'hFFFF))
        else $error("hreg back");
    a_index_range: assert property (app_index >= ITEMS |=>
        app_rdata == 16'h0000) else $error("far read");
    a_bit_width: assert property ($rose(tx_pin) |->
        low_run > 0 && low_run % BIT_CYCLES == 0) else $error("bit time");
    a_reply_quiet: assert property ($fell(tx_pin) |->
        rx_pin && $past(rx_pin, 8)) else $error("talk over");
    c_reply: cover property ($fell(tx_pin));
    c_far: cover property (app_index >= ITEMS);
    c_hreg: cover property (app_we && app_table == tbl_hreg);
endmodule
bind mbs_slave mbs_chk #(.ITEMS(ITEMS), .BIT_CYCLES(BIT_CYCLES)) chk (.clk,
    .nrst, .rx_pin, .tx_pin, .app_we, .app_table, .app_index, .app_wdata,
    .app_rdata);

//--- mbs_master.sv
`timescale 1ns/1ps
module mbs_master #(
    parameter int BC = 16
) (
    input wire logic clk,
    input wire logic tx_pin,
    output logic rx_pin = 1'b1
);
    logic [7:0] rq[$];
    logic perr = 1'b0;
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (q[i])
        begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task automatic send(input logic [7:0] q[$], input logic bad);
        logic [15:0] c = crc(q) ^ {15'h0000, bad};
        logic [10:0] w;
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        @(posedge clk) #1;
        foreach (q[i])
        begin
            w = {1'b1, ^q[i], q[i], 1'b0};
            for (int k = 0; k < 11; k++)
                #(BC * 5) rx_pin = w[k];
        end
        #(BC * 5);
    endtask
    always
    begin
        logic [10:0] w;
        @(negedge tx_pin);
        for (int k = 0; k < 11; k++)
            #(k == 0 ? BC * 2.5 : BC * 5) w[k] = tx_pin;
        perr = perr | w[0] | !w[10] | ^w[9:1];
        rq.push_back(w[8:1]);
    end
endmodule

//--- mbs_pkg.sv
package mbs_pkg;

    typedef enum logic [2:0] {
        st_recv,
        st_check,
        st_rd_bits,
        st_rd_regs,
        st_wr_bits,
        st_wr_regs,
        st_send
    } mbs_state_t;

    typedef enum logic [1:0] {
        tbl_coil,
        tbl_disc,
        tbl_ireg,
        tbl_hreg
    } mbs_table_t;

endpackage

//--- mbs_slave.sv
`timescale 1ns/1ps
`include "mbs_cfg.svh"

// Summary of operation
// - Serve function codes 01-06, 15 and 16.
// - Diagnostic 08 echoes only sub-function zero.
// - Ten thousand coils, ten thousand discrete inputs.
// - Ten thousand input and holding registers.
// - Per-item flag makes coil or register read-only.
// - Bus writes to protected items are dropped; application writes still land.
// - Block mode locks coils one to 7500.
// - Block mode locks holding registers up to 47500.
// - Every address below 10000 selects exactly one item; higher addresses are refused.
// - Eleven bit times per byte, even parity.
// - Read answers sized five plus data bytes.
// - Write answers are eight bytes, requests checked.
// - Multiple coil write carries 512 coils maximum.
// - Multiple coil write covers a contiguous range.

module mbs_slave #(
    parameter int ITEMS = `MBS_TABLE_ITEMS,
    parameter int IW = `MBS_INDEX_BITS,
    parameter int BLOCK_LIMIT = `MBS_BLOCK_LIMIT,
    parameter int BIT_CYCLES = `MBS_BIT_CYCLES,
    parameter int SILENCE_CYCLES = `MBS_SILENCE_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx_pin,
    output logic tx_pin,
    input wire logic [7:0] station_addr,
    input wire logic block_protect,
    input wire logic app_we,
    input wire mbs_pkg::mbs_table_t app_table,
    input wire logic [IW-1:0] app_index,
    input wire logic [15:0] app_wdata,
    output logic [15:0] app_rdata,
    input wire logic prot_we,
    input wire logic prot_hreg,
    input wire logic [IW-1:0] prot_index,
    input wire logic prot_flag
);
    import mbs_pkg::*;

    mbs_state_t state;
    logic rx_meta, rx_sync;
    logic rx_valid, rx_bad, tx_busy, tx_go;
    logic [7:0] rx_byte, tx_byte;
    logic [31:0] silence;
    logic gap_done, new_frame;
    logic [7:0] buf_mem [0:255];
    logic [8:0] len, resp_len, tx_idx;
    logic frame_bad;
    logic [15:0] crc_rx, crc_tx;
    logic [15:0] start_r, qty_r, cnt;
    logic [ITEMS-1:0] coil, disc, coil_prot, hreg_prot;
    logic [15:0] ireg [0:ITEMS-1];
    logic [15:0] hreg [0:ITEMS-1];
    logic [7:0] fc, exc, bit_bytes;
    logic [15:0] req_start, req_qty;
    logic [16:0] req_end;
    logic frame_ok, exec, bcast, last;
    logic [IW-1:0] one_idx, idx;
    logic [7:0] rd_a, wr_a;
    logic bit_val, wbit;
    logic [15:0] word_val, wword;
    logic c_lock_one, c_lock_item, h_lock_one, h_lock_item;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++)
            r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Line synchroniser.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end
        else
        begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    mbs_uart #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_uart (
        .clk(clk),
        .nrst(nrst),
        .rx(rx_sync),
        .tx_go(tx_go),
        .tx_byte(tx_byte),
        .tx(tx_pin),
        .tx_busy(tx_busy),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rx_bad(rx_bad)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame delimiting by line silence.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            silence <= 32'(SILENCE_CYCLES);
        else if (rx_valid)
            silence <= 32'h0000_0000;
        else if (!gap_done)
            silence <= silence + 32'h0000_0001;
    end

    assign gap_done = silence == 32'(SILENCE_CYCLES);
    assign new_frame = gap_done || len == 9'h000;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            len <= 9'h000;
            frame_bad <= 1'b0;
            crc_rx <= `MBS_CRC_INIT;
        end
        else if (state == st_recv && rx_valid)
        begin
            if (new_frame)
            begin
                len <= 9'h001;
                crc_rx <= crc_step(`MBS_CRC_INIT, rx_byte);
                frame_bad <= rx_bad;
            end
            else if (len == `MBS_BUF_BYTES)
                frame_bad <= 1'b1;
            else
            begin
                len <= len + 9'h001;
                crc_rx <= crc_step(crc_rx, rx_byte);
                frame_bad <= frame_bad | rx_bad;
            end
        end
        else if (state == st_check)
            len <= 9'h000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Request decode.
    always_comb
    begin
        fc = buf_mem[1];
        req_start = {buf_mem[2], buf_mem[3]};
        req_qty = {buf_mem[4], buf_mem[5]};
        req_end = {1'b0, req_start} + {1'b0, req_qty};
        bit_bytes = 8'((req_qty + 16'h0007) >> 3);
        bcast = buf_mem[0] == `MBS_BROADCAST;
        frame_ok = len >= `MBS_MIN_FRAME && crc_rx == 16'h0000 &&
                   !frame_bad && (bcast || buf_mem[0] == station_addr);
        exc = `MBS_EXC_NONE;
        case (fc)
            `MBS_FC_RD_COILS, `MBS_FC_RD_DISC:
                if (len != `MBS_FIXED_REQ || req_qty == 16'h0000 ||
                    req_qty > `MBS_MAX_RD_BITS)
                    exc = `MBS_EXC_VALUE;
                else if (req_end > 17'(ITEMS))
                    exc = `MBS_EXC_ADDR;
            `MBS_FC_RD_HOLD, `MBS_FC_RD_INPUT:
                if (len != `MBS_FIXED_REQ || req_qty == 16'h0000 ||
                    req_qty > `MBS_MAX_RD_REGS)
                    exc = `MBS_EXC_VALUE;
                else if (req_end > 17'(ITEMS))
                    exc = `MBS_EXC_ADDR;
            `MBS_FC_WR_COIL:
                if (len != `MBS_FIXED_REQ ||
                    (req_qty != `MBS_COIL_ON && req_qty != `MBS_COIL_OFF))
                    exc = `MBS_EXC_VALUE;
                else if (req_start >= 16'(ITEMS))
                    exc = `MBS_EXC_ADDR;
            `MBS_FC_WR_REG:
                if (len != `MBS_FIXED_REQ)
                    exc = `MBS_EXC_VALUE;
                else if (req_start >= 16'(ITEMS))
                    exc = `MBS_EXC_ADDR;
            `MBS_FC_DIAG:
                if (req_start != 16'h0000)
                    exc = `MBS_EXC_FUNC;
            `MBS_FC_WR_COILS:
                if (req_qty == 16'h0000 || req_qty > `MBS_MAX_WR_COILS ||
                    buf_mem[6] != bit_bytes ||
                    len != `MBS_MULTI_BASE + {1'b0, buf_mem[6]})
                    exc = `MBS_EXC_VALUE;
                else if (req_end > 17'(ITEMS))
                    exc = `MBS_EXC_ADDR;
            `MBS_FC_WR_REGS:
                if (req_qty == 16'h0000 || req_qty > `MBS_MAX_WR_REGS ||
                    buf_mem[6] != 8'(req_qty << 1) ||
                    len != `MBS_MULTI_BASE + {1'b0, buf_mem[6]})
                    exc = `MBS_EXC_VALUE;
                else if (req_end > 17'(ITEMS))
                    exc = `MBS_EXC_ADDR;
            default:
                exc = `MBS_EXC_FUNC;
        endcase
        exec = state == st_check && frame_ok && exc == `MBS_EXC_NONE;
    end

    // Item addressing, one item per address.
    assign one_idx = IW'(req_start);
    assign idx = IW'(start_r + cnt);
    assign last = cnt == qty_r - 16'h0001;
    assign rd_a = 8'(`MBS_RD_HDR + (cnt >> 3));
    assign wr_a = 8'(`MBS_WR_HDR + (cnt >> 3));
    assign bit_val = fc == `MBS_FC_RD_COILS ? coil[idx] : disc[idx];
    assign word_val = fc == `MBS_FC_RD_HOLD ? hreg[idx] : ireg[idx];
    assign wbit = buf_mem[wr_a][cnt[2:0]];
    assign wword = {buf_mem[8'(`MBS_WR_HDR + (cnt << 1))],
                    buf_mem[8'(`MBS_WR_HDR + (cnt << 1) + 16'h0001)]};
    assign c_lock_one = coil_prot[one_idx] ||
                        (block_protect && one_idx < IW'(BLOCK_LIMIT));
    assign c_lock_item = coil_prot[idx] ||
                         (block_protect && idx < IW'(BLOCK_LIMIT));
    assign h_lock_one = hreg_prot[one_idx] ||
                        (block_protect && one_idx < IW'(BLOCK_LIMIT));
    assign h_lock_item = hreg_prot[idx] ||
                         (block_protect && idx < IW'(BLOCK_LIMIT));

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            state <= st_recv;
        else
            case (state)
                st_recv:
                    if (len != 9'h000 && gap_done)
                        state <= st_check;
                st_check:
                    if (!frame_ok)
                        state <= st_recv;
                    else if (exc != `MBS_EXC_NONE)
                        state <= bcast ? st_recv : st_send;
                    else if (fc == `MBS_FC_RD_COILS || fc == `MBS_FC_RD_DISC)
                        state <= bcast ? st_recv : st_rd_bits;
                    else if (fc == `MBS_FC_RD_HOLD || fc == `MBS_FC_RD_INPUT)
                        state <= bcast ? st_recv : st_rd_regs;
                    else if (fc == `MBS_FC_WR_COILS)
                        state <= st_wr_bits;
                    else if (fc == `MBS_FC_WR_REGS)
                        state <= st_wr_regs;
                    else
                        state <= bcast ? st_recv : st_send;
                st_rd_bits, st_rd_regs, st_wr_bits, st_wr_regs:
                    if (last)
                        state <= bcast ? st_recv : st_send;
                st_send:
                    if (tx_idx == resp_len + `MBS_CRC_BYTES && !tx_busy && !tx_go)
                        state <= st_recv;
                default:
                    state <= st_recv;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            start_r <= 16'h0000;
            qty_r <= 16'h0000;
            cnt <= 16'h0000;
            resp_len <= 9'h000;
        end
        else if (state == st_check)
        begin
            start_r <= req_start;
            qty_r <= req_qty;
            cnt <= 16'h0000;
            if (exc != `MBS_EXC_NONE)
                resp_len <= `MBS_EXC_LEN;
            else if (fc == `MBS_FC_RD_COILS || fc == `MBS_FC_RD_DISC)
                resp_len <= `MBS_EXC_LEN + {1'b0, bit_bytes};
            else if (fc == `MBS_FC_RD_HOLD || fc == `MBS_FC_RD_INPUT)
                resp_len <= `MBS_EXC_LEN + 9'(req_qty << 1);
            else if (fc == `MBS_FC_DIAG)
                resp_len <= len - `MBS_CRC_BYTES;
            else
                resp_len <= `MBS_ECHO_LEN;
        end
        else if (state != st_recv && state != st_send)
            cnt <= cnt + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame buffer; answers built in place.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 256; i++)
                buf_mem[i] <= 8'h00;
        end
        else
            case (state)
                st_recv:
                    if (rx_valid && new_frame)
                        buf_mem[0] <= rx_byte;
                    else if (rx_valid && len != `MBS_BUF_BYTES)
                        buf_mem[len[7:0]] <= rx_byte;
                st_check:
                    if (frame_ok && exc != `MBS_EXC_NONE)
                    begin
                        buf_mem[1] <= fc | `MBS_EXC_FLAG;
                        buf_mem[2] <= exc;
                    end
                    else if (fc == `MBS_FC_RD_COILS || fc == `MBS_FC_RD_DISC)
                        buf_mem[2] <= bit_bytes;
                    else if (fc == `MBS_FC_RD_HOLD || fc == `MBS_FC_RD_INPUT)
                        buf_mem[2] <= 8'(req_qty << 1);
                st_rd_bits:
                    if (cnt[2:0] == 3'h0)
                        buf_mem[rd_a] <= {7'h00, bit_val};
                    else
                        buf_mem[rd_a][cnt[2:0]] <= bit_val;
                st_rd_regs:
                begin
                    buf_mem[8'(`MBS_RD_HDR + (cnt << 1))] <= word_val[15:8];
                    buf_mem[8'(`MBS_RD_HDR + (cnt << 1) + 16'h0001)] <=
                        word_val[7:0];
                end
                default:
                    ;
            endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Data tables; bus writes beat the application.
    always_ff @(posedge clk)
    begin
        if (!nrst)
            coil <= '0;
        else if (exec && fc == `MBS_FC_WR_COIL)
        begin
            if (!c_lock_one)
                coil[one_idx] <= req_qty == `MBS_COIL_ON;
        end
        else if (state == st_wr_bits)
        begin
            if (!c_lock_item)
                coil[idx] <= wbit;
        end
        else if (app_we && app_table == tbl_coil && app_index < IW'(ITEMS))
            coil[app_index] <= app_wdata[0];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            for (int i = 0; i < ITEMS; i++)
                hreg[i] <= 16'h0000;
        else if (exec && fc == `MBS_FC_WR_REG)
        begin
            if (!h_lock_one)
                hreg[one_idx] <= req_qty;
        end
        else if (state == st_wr_regs)
        begin
            if (!h_lock_item)
                hreg[idx] <= wword;
        end
        else if (app_we && app_table == tbl_hreg && app_index < IW'(ITEMS))
            hreg[app_index] <= app_wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            disc <= '0;
            for (int i = 0; i < ITEMS; i++)
                ireg[i] <= 16'h0000;
        end
        else if (app_we && app_index < IW'(ITEMS))
        begin
            if (app_table == tbl_disc)
                disc[app_index] <= app_wdata[0];
            else if (app_table == tbl_ireg)
                ireg[app_index] <= app_wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            coil_prot <= '0;
            hreg_prot <= '0;
        end
        else if (prot_we && prot_index < IW'(ITEMS))
        begin
            if (prot_hreg)
                hreg_prot[prot_index] <= prot_flag;
            else
                coil_prot[prot_index] <= prot_flag;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            app_rdata <= 16'h0000;
        else if (app_index >= IW'(ITEMS))
            app_rdata <= 16'h0000;
        else
            case (app_table)
                tbl_coil: app_rdata <= {15'h0000, coil[app_index]};
                tbl_disc: app_rdata <= {15'h0000, disc[app_index]};
                tbl_ireg: app_rdata <= ireg[app_index];
                default: app_rdata <= hreg[app_index];
            endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Answer out, CRC low byte first.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tx_idx <= 9'h000;
            tx_go <= 1'b0;
            tx_byte <= 8'h00;
            crc_tx <= `MBS_CRC_INIT;
        end
        else if (state != st_send)
        begin
            tx_idx <= 9'h000;
            tx_go <= 1'b0;
            crc_tx <= `MBS_CRC_INIT;
        end
        else if (tx_go)
            tx_go <= 1'b0;
        else if (!tx_busy && tx_idx != resp_len + `MBS_CRC_BYTES)
        begin
            tx_go <= 1'b1;
            tx_idx <= tx_idx + 9'h001;
            if (tx_idx < resp_len)
            begin
                tx_byte <= buf_mem[tx_idx[7:0]];
                crc_tx <= crc_step(crc_tx, buf_mem[tx_idx[7:0]]);
            end
            else if (tx_idx == resp_len)
                tx_byte <= crc_tx[7:0];
            else
                tx_byte <= crc_tx[15:8];
        end
    end

endmodule

//--- mbs_uart.sv
`timescale 1ns/1ps
`include "mbs_cfg.svh"

module mbs_uart #(
    parameter int BIT_CYCLES = `MBS_BIT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic rx,
    input wire logic tx_go,
    input wire logic [7:0] tx_byte,
    output logic tx,
    output logic tx_busy,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_bad
);
    localparam int CW = $clog2(BIT_CYCLES + 1);

    logic rx_on;
    logic [CW-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [9:0] rx_sh;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic [CW-1:0] tx_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Receiver, sampled mid-bit.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rx_on <= 1'b0;
            rx_cnt <= '0;
            rx_bit <= 4'h0;
            rx_sh <= 10'h000;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            rx_bad <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            if (!rx_on)
            begin
                if (!rx)
                begin
                    rx_on <= 1'b1;
                    rx_cnt <= CW'(BIT_CYCLES / 2);
                    rx_bit <= 4'h0;
                end
            end
            else if (rx_cnt != '0)
                rx_cnt <= rx_cnt - 1'b1;
            else
            begin
                rx_cnt <= CW'(BIT_CYCLES - 1);
                rx_bit <= rx_bit + 4'h1;
                rx_sh <= {rx, rx_sh[9:1]};
                if (rx_bit == 4'h0 && rx)
                    rx_on <= 1'b0;
                else if (rx_bit == `MBS_CHAR_BITS - 4'h1)
                begin
                    rx_on <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_byte <= rx_sh[8:1];
                    rx_bad <= !rx || ((^rx_sh[8:1]) != rx_sh[9]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tx <= 1'b1;
            tx_busy <= 1'b0;
            tx_sh <= 11'h7FF;
            tx_left <= 4'h0;
            tx_cnt <= '0;
        end
        else if (tx_go && !tx_busy)
        begin
            tx_sh <= {1'b1, ^tx_byte, tx_byte, 1'b0};
            tx_left <= `MBS_CHAR_BITS;
            tx_cnt <= '0;
            tx_busy <= 1'b1;
        end
        else if (tx_busy)
        begin
            if (tx_cnt != '0)
                tx_cnt <= tx_cnt - 1'b1;
            else if (tx_left == 4'h0)
            begin
                tx_busy <= 1'b0;
                tx <= 1'b1;
            end
            else
            begin
                tx <= tx_sh[0];
                tx_sh <= {1'b1, tx_sh[10:1]};
                tx_left <= tx_left - 4'h1;
                tx_cnt <= CW'(BIT_CYCLES - 1);
            end
        end
    end

endmodule

//--- tb.sv
`timescale 1ns/1ps
module tb;
    import mbs_pkg::*;
    logic clk = 0, nrst = 0, app_we = 0, block_protect = 0, tx_pin, rx_pin;
    logic prot_we = 0, prot_hreg = 1, prot_flag = 1;
    logic [7:0] station_addr = 8'h11, r[$], f[$];
    mbs_table_t app_table = tbl_coil;
    logic [13:0] app_index = 0, prot_index = 14'h0007;
    logic [15:0] app_wdata = 0, app_rdata, d;
    int err_count = 0, comparisons = 0;
    mbs_slave #(.BIT_CYCLES(16), .SILENCE_CYCLES(616)) dut (.clk, .nrst,
        .rx_pin, .tx_pin, .station_addr, .block_protect, .app_we, .app_table,
        .app_index, .app_wdata, .app_rdata, .prot_we, .prot_hreg,
        .prot_index, .prot_flag);
    mbs_master m (.clk, .tx_pin, .rx_pin);
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic ok, input string s);
        comparisons++;
        err_count += int'(ok !== 1'b1);
        if (ok !== 1'b1)
            $display("BAD %0t %s", $time, s);
    endtask
    task automatic app(input mbs_table_t t, input logic [13:0] i,
        input logic [15:0] v, input logic we);
        app_table = t;
        app_index = i;
        app_wdata = v;
        app_we = we;
        @(posedge clk);
        #1 app_we = 0;
        repeat (2) @(posedge clk);
        #1 d = app_rdata;
    endtask
    task automatic xfer(input logic [7:0] q[$], input logic bad, input int n,
        input logic [7:0] b1, b2);
        m.rq.delete();
        m.send(q, bad);
        for (int i = 0; i < 4000 && m.rq.size() < n; i++)
            @(posedge clk);
        repeat (700) @(posedge clk);
        #1 r = m.rq;
        chk(r.size() == n && !m.perr && (n == 0 ||
            m.crc(r) == 0 && r[1] == b1 && r[2] == b2), "reply");
    endtask
    task automatic wr1(input logic [7:0] fc, input logic [15:0] a, v,
        input logic ok);
        xfer({8'h11, fc, a[15:8], a[7:0], v[15:8], v[7:0]}, 0, 8, fc, a[15:8]);
        app(fc == 8'h05 ? tbl_coil : tbl_hreg, a[13:0], 16'h0000, 0);
        chk(d === (ok ? (fc == 8'h05 ? 16'h0001 : v) : 16'h0000), "stored");
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_reads();
        logic [15:0] e[4] = '{16'h0002, 16'h0100, 16'h1234, 16'h0BEE};
        app(tbl_coil, 14'h0009, 16'h0001, 1);
        app(tbl_disc, 14'h0000, 16'h0001, 1);
        app(tbl_hreg, 14'h0000, 16'h1234, 1);
        app(tbl_ireg, 14'h0000, 16'h0BEE, 1);
        for (int c = 1; c < 5; c++)
        begin
            xfer({8'h11, 8'(c), 8'h00, 8'h00, 8'h00, c < 3 ? 8'h0A : 8'h01},
                0, 7, 8'(c), 8'h02);
            chk({r[3], r[4]} === e[c - 1], "read data");
        end
        app(tbl_hreg, 14'h3FFF, 16'h0000, 0);
        chk(d === 16'h0000, "far read");
    endtask
    task automatic t_writes();
        prot_we = 1;
        @(posedge clk);
        #1 prot_we = 0;
        wr1(8'h06, 16'h0007, 16'h5555, 0);
        wr1(8'h06, 16'h0008, 16'h5555, 1);
        block_protect = 1;
        wr1(8'h05, 16'h1D4B, 16'hFF00, 0);
        wr1(8'h05, 16'h1D4C, 16'hFF00, 1);
        wr1(8'h06, 16'h1D4B, 16'h00AA, 0);
        wr1(8'h06, 16'h1D4C, 16'h00AA, 1);
        block_protect = 0;
    endtask
    task automatic t_multi();
        xfer({8'h11, 8'h0F, 8'h1D, 8'h4C, 8'h00, 8'h0A, 8'h02, 8'h03, 8'h02},
            0, 8, 8'h0F, 8'h1D);
        app(tbl_coil, 14'h1D55, 16'h0000, 0);
        chk(d[0] === 1'b1, "last coil");
        app(tbl_coil, 14'h1D54, 16'h0000, 0);
        chk(d[0] === 1'b0, "gap coil");
        xfer({8'h11, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34},
            0, 8, 8'h10, 8'h00);
        app(tbl_hreg, 14'h0020, 16'h0000, 0);
        chk(d === 16'h1234, "multi reg");
        f = {8'h11, 8'h0F, 8'h00, 8'h00, 8'h02, 8'h01, 8'h41};
        repeat (65) f.push_back(8'hFF);
        xfer(f, 0, 5, 8'h8F, 8'h03);
    endtask
    task automatic t_errors();
        xfer({8'h11, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01}, 0, 5, 8'h87, 8'h01);
        xfer({8'h11, 8'h03, 8'h27, 8'h0F, 8'h00, 8'h02}, 0, 5, 8'h83, 8'h02);
        xfer({8'h11, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 0, 8, 8'h08, 8'h00);
        xfer({8'h11, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, 0, 5, 8'h88, 8'h01);
        xfer({8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1, 0, 0, 0);
        xfer({8'h12, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0, 0, 0, 0);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        #1 nrst = 1;
        t_reads();
        t_writes();
        t_multi();
        t_errors();
        results();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        results();
    end
endmodule
